// File: inc/spm_pkg.sv
// shared constants and types for the serial port mode and buffer interrupt block
package spm_pkg;
	// register byte offsets
	localparam logic [7:0] SPM_CTRL_OFS = 8'h00; // serial_port_control
	localparam logic [7:0] SPM_STAT_OFS = 8'h04; // sticky event status, read only
	localparam logic [7:0] SPM_CLR_OFS = 8'h08; // write one to clear status, write only
	localparam logic [7:0] SPM_IEN_OFS = 8'h0C; // interrupt enable, same layout as status
	localparam logic [7:0] SPM_DATA_OFS = 8'h10; // write: tx push, read: rx pop
	localparam logic [7:0] SPM_LVL_OFS = 8'h14; // buffer fill levels and busy
	// control field positions
	localparam int SPM_ON_BIT = 15;
	localparam int SPM_FRM_BIT = 14;
	localparam int SPM_AUD_BIT = 13;
	localparam int SPM_CKP_BIT = 6;
	localparam int SPM_MST_BIT = 5;
	localparam int SPM_REL_BIT = 4;
	localparam int SPM_TXS_LO = 2;
	localparam int SPM_RXS_LO = 0;
	// status bit positions
	localparam int SPM_ST_TX = 0;
	localparam int SPM_ST_RX = 1;
	localparam int SPM_ST_OVF = 2;
	localparam int SPM_NSTAT = 3;
	// reset values
	localparam logic [31:0] SPM_CTRL_RST = 32'h0000_0000;
	localparam logic [2:0] SPM_STAT_RST = 3'h0;
	// buffer interrupt select codes
	localparam logic [1:0] SPM_SEL_DONE = 2'h0;
	localparam logic [1:0] SPM_SEL_ONE = 2'h1;
	localparam logic [1:0] SPM_SEL_HALF = 2'h2;
	localparam logic [1:0] SPM_SEL_MOST = 2'h3;
	// serial clock timing: least period 40 ns, bus clock 25 ns
	localparam int SPM_SCK_MIN_NS = 40;
	localparam int SPM_CLK_NS = 25;
	localparam int SPM_HALF_RAW = (SPM_SCK_MIN_NS / 2 + SPM_CLK_NS - 1) / SPM_CLK_NS;
	localparam int SPM_HALF_CYC = (SPM_HALF_RAW < 1) ? 1 : SPM_HALF_RAW;
	localparam int SPM_WORD_BITS = 8;
	// control fields as stored
	typedef struct packed {
		logic on;
		logic framed;
		logic audio;
		logic cpol;
		logic master;
		logic release_in;
		logic [1:0] txsel;
		logic [1:0] rxsel;
	} spm_ctrl_t;
	// serial pin group toward the link
	typedef struct packed {
		logic sck;
		logic sck_oe;
		logic sdo;
		logic sdo_oe;
	} spm_pins_t;
endpackage : spm_pkg

// File: logic/spm_core.sv
// serial port role select, input release and buffer interrupt logic with a wishbone slave
//
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
module spm_core import spm_pkg::*; #(
	parameter int DEPTH = 4, // buffer words per direction
	parameter int HALF_CYC = SPM_HALF_CYC // master half period in clocks
) (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [7:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	input wire logic SCK_I,
	input wire logic SDI_I,
	input wire logic SS_N_I,
	output spm_pins_t PINS_O,
	output logic SDI_RELEASED_O,
	output logic TX_REQ_O,
	output logic RX_REQ_O,
	output logic IRQ_O
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_C = (AW+1)'(DEPTH);
	localparam logic [AW:0] HALFW_C = (AW+1)'(DEPTH / 2);
	localparam logic [7:0] HALF_C = 8'(HALF_CYC - 1);

	// level decode of one buffer request, shared by both directions
	function automatic logic buf_req(input logic [1:0] sel, input logic [AW:0] cnt,
			input logic done, input logic is_tx);
		logic r;
		r = 1'b0;
		unique case (sel)
			SPM_SEL_MOST: r = is_tx ? (cnt != FULL_C) : (cnt == FULL_C);
			SPM_SEL_HALF: r = is_tx ? (cnt <= HALFW_C) : (cnt >= HALFW_C);
			SPM_SEL_ONE: r = is_tx ? (cnt == '0) : (cnt != '0);
			SPM_SEL_DONE: r = done;
		endcase
		return r;
	endfunction : buf_req

	spm_ctrl_t ctrl_r; // stored control fields
	logic [SPM_NSTAT-1:0] stat_r; // sticky events
	logic [SPM_NSTAT-1:0] ien_r; // interrupt enables
	logic ack_r; // wishbone acknowledge
	logic [31:0] dat_r; // read data
	logic [7:0] txm_r [DEPTH]; // transmit buffer words
	logic [7:0] rxm_r [DEPTH]; // receive buffer words
	logic [AW-1:0] txw_r, txr_r, rxw_r, rxr_r; // buffer pointers
	logic [AW:0] txc_r, rxc_r; // buffer fill counts
	logic sck_s1_r, sck_s2_r, sck_s3_r; // link clock sync and history
	logic sdi_s1_r, sdi_s2_r, ss_s1_r, ss_s2_r; // pin syncs
	logic busy_r, phase_r, smp_r, txdone_r, rxdrain_r; // engine state
	logic [7:0] shf_r; // shift register
	logic [3:0] bit_r; // bits shifted this word
	logic [7:0] div_r; // master half-period divider

	// bus decode
	logic wr_fire, rd_fire, cpol_eff, rel_eff, sdi_in, ss_act, tick;
	logic lead, trail, start, word_end, tx_push, tx_pop, rx_push, rx_pop;
	assign wr_fire = CYC_I & STB_I & ack_r & WE_I;
	assign rd_fire = CYC_I & STB_I & ack_r & ~WE_I;

	// wishbone: ack one cycle after request, dropped the cycle after
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= CYC_I & STB_I & ~ack_r;
		end
	end

	// read data is captured in the request cycle and held with ack
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			dat_r <= '0;
		end else if (CYC_I & STB_I & ~ack_r) begin
			unique case (ADR_I)
				SPM_CTRL_OFS: dat_r <= {16'h0000, ctrl_r.on, ctrl_r.framed, ctrl_r.audio, 6'h00,
					ctrl_r.cpol, ctrl_r.master, ctrl_r.release_in, ctrl_r.txsel, ctrl_r.rxsel};
				SPM_STAT_OFS: dat_r <= {29'h0, stat_r};
				SPM_IEN_OFS: dat_r <= {29'h0, ien_r};
				SPM_DATA_OFS: dat_r <= {24'h0, rxm_r[rxr_r]};
				SPM_LVL_OFS: dat_r <= {15'h0, busy_r, 8'(rxc_r), 8'(txc_r)};
				default: dat_r <= '0; // unmapped and write-only read zero
			endcase
		end
	end
	assign DAT_O = dat_r;
	assign ACK_O = ack_r;

	// control register; role, polarity and modes only while module off
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ctrl_r <= spm_ctrl_t'({SPM_CTRL_RST[15:13], SPM_CTRL_RST[6:0]});
		end else if (wr_fire && ADR_I == SPM_CTRL_OFS) begin
			if (SEL_I[0]) begin
				ctrl_r.release_in <= DAT_I[SPM_REL_BIT];
				ctrl_r.txsel <= DAT_I[SPM_TXS_LO +: 2];
				ctrl_r.rxsel <= DAT_I[SPM_RXS_LO +: 2];
				if (!ctrl_r.on) begin
					ctrl_r.cpol <= DAT_I[SPM_CKP_BIT];
					ctrl_r.master <= DAT_I[SPM_MST_BIT];
				end
			end
			if (SEL_I[1]) begin
				ctrl_r.on <= DAT_I[SPM_ON_BIT];
				if (!ctrl_r.on) begin
					ctrl_r.framed <= DAT_I[SPM_FRM_BIT];
					ctrl_r.audio <= DAT_I[SPM_AUD_BIT];
				end
			end
		end
	end

	// interrupt enable register
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ien_r <= SPM_STAT_RST;
		end else if (wr_fire && ADR_I == SPM_IEN_OFS && SEL_I[0]) begin
			ien_r <= DAT_I[SPM_NSTAT-1:0];
		end
	end

	// two-flop syncs; the third clock flop only keeps history for edges
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			{sck_s1_r, sck_s2_r, sck_s3_r} <= 3'h0;
			{sdi_s1_r, sdi_s2_r} <= 2'h0;
			{ss_s1_r, ss_s2_r} <= 2'h3;
		end else begin
			{sck_s1_r, sck_s2_r, sck_s3_r} <= {SCK_I, sck_s1_r, sck_s2_r};
			{sdi_s1_r, sdi_s2_r} <= {SDI_I, sdi_s1_r};
			{ss_s1_r, ss_s2_r} <= {SS_N_I, ss_s1_r};
		end
	end

	assign cpol_eff = ctrl_r.audio | ctrl_r.cpol;
	assign rel_eff = ctrl_r.release_in & ~ctrl_r.framed;
	assign sdi_in = rel_eff ? 1'b0 : sdi_s2_r;
	assign SDI_RELEASED_O = rel_eff;
	assign ss_act = ~ss_s2_r;
	assign tick = (div_r == HALF_C);

	// master ticks its own phase, slave follows synced clock edges
	always_comb begin
		if (ctrl_r.master) begin
			lead = busy_r & tick & ~phase_r;
			trail = busy_r & tick & phase_r;
		end else begin
			lead = busy_r & ((sck_s2_r ^ cpol_eff) & ~(sck_s3_r ^ cpol_eff));
			trail = busy_r & (~(sck_s2_r ^ cpol_eff) & (sck_s3_r ^ cpol_eff));
		end
	end
	assign start = ctrl_r.on & ~busy_r & (ctrl_r.master ? (txc_r != '0) : ss_act);
	assign word_end = trail & (bit_r == 4'(SPM_WORD_BITS - 1));
	assign tx_pop = start & (txc_r != '0);
	assign tx_push = wr_fire & (ADR_I == SPM_DATA_OFS) & SEL_I[0] & (txc_r != FULL_C);
	assign rx_push = word_end & (rxc_r != FULL_C);
	assign rx_pop = rd_fire & (ADR_I == SPM_DATA_OFS) & (rxc_r != '0);

	// master half-period divider, enable pulse only
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			div_r <= '0;
		end else if (!busy_r || tick) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 8'h01;
		end
	end

	// shift engine: sample on leading edge, shift on trailing edge
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			busy_r <= 1'b0;
			phase_r <= 1'b0;
			smp_r <= 1'b0;
			bit_r <= '0;
			shf_r <= '0;
		end else if (!ctrl_r.on || (!ctrl_r.master && !ss_act)) begin
			busy_r <= 1'b0; // off or deselected aborts the word
			phase_r <= 1'b0;
			bit_r <= '0;
		end else if (start) begin
			busy_r <= 1'b1;
			phase_r <= 1'b0;
			bit_r <= '0;
			shf_r <= (txc_r != '0) ? txm_r[txr_r] : 8'h00; // slave sends zero when empty
		end else if (lead) begin
			smp_r <= sdi_in;
			phase_r <= 1'b1;
		end else if (trail) begin
			shf_r <= {shf_r[6:0], smp_r};
			phase_r <= 1'b0;
			bit_r <= bit_r + 4'h1;
			busy_r <= ~word_end;
		end
	end

	// transmit buffer storage and pointers
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			txw_r <= '0;
			txr_r <= '0;
			txc_r <= '0;
			for (int i = 0; i < DEPTH; i++) txm_r[i] <= '0;
		end else begin
			if (tx_push) begin
				txm_r[txw_r] <= DAT_I[7:0];
				txw_r <= (txw_r == AW'(DEPTH - 1)) ? '0 : txw_r + AW'(1);
			end
			if (tx_pop) txr_r <= (txr_r == AW'(DEPTH - 1)) ? '0 : txr_r + AW'(1);
			txc_r <= txc_r + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
		end
	end

	// receive buffer storage and pointers; full buffer drops the word
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rxw_r <= '0;
			rxr_r <= '0;
			rxc_r <= '0;
			for (int i = 0; i < DEPTH; i++) rxm_r[i] <= '0;
		end else begin
			if (rx_push) begin
				rxm_r[rxw_r] <= {shf_r[6:0], smp_r}; // word as it stands after the last shift
				rxw_r <= (rxw_r == AW'(DEPTH - 1)) ? '0 : rxw_r + AW'(1);
			end
			if (rx_pop) rxr_r <= (rxr_r == AW'(DEPTH - 1)) ? '0 : rxr_r + AW'(1);
			rxc_r <= rxc_r + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
		end
	end

	// completion markers for the select-00 modes
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			txdone_r <= 1'b0;
			rxdrain_r <= 1'b0;
		end else begin
			if (tx_push) txdone_r <= 1'b0;
			else if (word_end && txc_r == '0) txdone_r <= 1'b1;
			if (rx_push) rxdrain_r <= 1'b0;
			else if (rx_pop && rxc_r == (AW+1)'(1)) rxdrain_r <= 1'b1;
		end
	end

	// buffer requests stay high while the chosen condition holds
	assign TX_REQ_O = ctrl_r.on & buf_req(ctrl_r.txsel, txc_r, txdone_r, 1'b1);
	assign RX_REQ_O = ctrl_r.on & buf_req(ctrl_r.rxsel, rxc_r, rxdrain_r, 1'b0);

	// sticky status: a set in the clearing cycle wins
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			stat_r <= SPM_STAT_RST;
		end else begin
			for (int i = 0; i < SPM_NSTAT; i++) begin
				if (wr_fire && ADR_I == SPM_CLR_OFS && SEL_I[0] && DAT_I[i]) stat_r[i] <= 1'b0;
			end
			if (TX_REQ_O) stat_r[SPM_ST_TX] <= 1'b1;
			if (RX_REQ_O) stat_r[SPM_ST_RX] <= 1'b1;
			if (word_end && rxc_r == FULL_C) stat_r[SPM_ST_OVF] <= 1'b1;
		end
	end
	assign IRQ_O = |(stat_r & ien_r);

	// pin drive: clock only as master, data out as master or while selected
	assign PINS_O.sck = phase_r ^ cpol_eff;
	assign PINS_O.sck_oe = ctrl_r.on & ctrl_r.master;
	assign PINS_O.sdo = shf_r[7];
	assign PINS_O.sdo_oe = ctrl_r.on & (ctrl_r.master | ss_act);

	// checks
	sequence ctrl_wr_on_s;
		wr_fire && ADR_I == SPM_CTRL_OFS && SEL_I[0] && ctrl_r.on;
	endsequence
	sequence last_out_s;
		word_end && txc_r == '0 && !tx_push;
	endsequence
	role_pins_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		PINS_O.sck_oe == (ctrl_r.on && ctrl_r.master)) else $error("clock drive role wrong");
	sck_tick_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		ctrl_r.on && ctrl_r.master && busy_r && !tick |=> $stable(PINS_O.sck))
		else $error("master clock moved off a divider tick");
	sdi_release_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		rel_eff && lead |=> !smp_r) else $error("released input was sampled");
	tx_empty_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		ctrl_r.on && ctrl_r.txsel == SPM_SEL_ONE |-> TX_REQ_O == (txc_r == '0))
		else $error("tx empty request wrong");
	tx_done_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		ctrl_r.on && ctrl_r.txsel == SPM_SEL_DONE && !tx_push ##0 last_out_s |=> TX_REQ_O)
		else $error("tx done request missing");
	rx_full_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		ctrl_r.on && ctrl_r.rxsel == SPM_SEL_MOST |-> RX_REQ_O == (rxc_r == FULL_C))
		else $error("rx full request wrong");
	rx_drain_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		rx_pop && rxc_r == (AW+1)'(1) && !rx_push |=> rxdrain_r && rxc_r == '0)
		else $error("rx drain marker missing");
	ctrl_lock_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		ctrl_wr_on_s |=> $stable(ctrl_r.master) && $stable(ctrl_r.cpol))
		else $error("protected bit changed while on");
	audio_pol_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		ctrl_r.audio && !busy_r |-> PINS_O.sck) else $error("audio idle clock not high");
	framed_rel_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		ctrl_r.framed |-> !SDI_RELEASED_O) else $error("release honoured in framed mode");
	req_level_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		!ctrl_r.on |-> !TX_REQ_O && !RX_REQ_O) else $error("request while module off");
endmodule : spm_core

// File: testbench/spm_far.sv
// far-side serial device: slave to our master, or master clocking our slave
`timescale 1ns/10ps
module spm_far import spm_pkg::*; (
	input wire spm_pins_t pins_i,
	output logic sck_o,
	output logic sdi_o,
	output logic ss_n_o
);
	logic [7:0] out_w = 8'hA5; // word sent back, rotates home each byte
	logic [7:0] in_w = 8'h00; // last byte taken from our data out
	// link idle: no clock, not selected
	initial begin
		sck_o = 1'b0;
		ss_n_o = 1'b1;
	end
	// outside frames show the inverse, so stale data never passes as good
	assign sdi_o = (pins_i.sck_oe | ~ss_n_o) ? out_w[7] : ~out_w[7];
	// follow the block's clock: sample on leading, shift on trailing
	always @(posedge pins_i.sck) if (pins_i.sck_oe) in_w = {in_w[6:0], pins_i.sdo};
	always @(negedge pins_i.sck) if (pins_i.sck_oe) out_w = {out_w[6:0], out_w[7]};
	// one byte as link master, 200 ns clock only while selected
	task automatic drive_word();
		ss_n_o = 1'b0;
		#400;
		repeat (8) begin
			sck_o = 1'b1;
			in_w = {in_w[6:0], pins_i.sdo};
			#100;
			sck_o = 1'b0;
			out_w = {out_w[6:0], out_w[7]};
			#100;
		end
		#400;
		ss_n_o = 1'b1;
	endtask : drive_word
endmodule : spm_far

// File: testbench/tb_spi_mode_and_buffer_irq_select.sv
// self-checking bench for the serial mode and buffer interrupt block
`timescale 1ns/10ps
module tb_spi_mode_and_buffer_irq_select import spm_pkg::*; ;
	logic clk = 1'b0; // bus clock
	logic rst_n = 1'b0; // async reset, low active
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // bus request
	logic [7:0] adr = 8'h00; // byte address
	logic [31:0] wdat = 32'h0; // write data
	logic [31:0] rdat; // read data
	logic ack, txq, rxq, irq, rel; // block outputs
	logic sck_x, sdi_x, ss_n_x; // far side lines
	spm_pins_t pins; // serial pins
	logic [31:0] exp_q[$]; // expected read words
	logic [31:0] seed = 32'h8314_5C2D; // random state
	logic [7:0] last_w = 8'h00; // last accepted tx word
	logic [17:0] pin_tab [4] = '{{16'h2000, 2'b10}, {16'h0040, 2'b10},
		{16'h0010, 2'b01}, {16'h4010, 2'b00}}; // control, {idle clock, released}
	int num_errors = 0;
	int num_checks = 0;
	// 40 MHz
	always #12.5 clk = ~clk;
	spm_core #(.DEPTH(4), .HALF_CYC(4)) spm_core_inst (.CLK_I(clk), .RST_N_I(rst_n),
		.CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(wdat),
		.DAT_O(rdat), .ACK_O(ack), .SCK_I(sck_x), .SDI_I(sdi_x), .SS_N_I(ss_n_x),
		.PINS_O(pins), .SDI_RELEASED_O(rel), .TX_REQ_O(txq), .RX_REQ_O(rxq), .IRQ_O(irq));
	spm_far spm_far_inst (.pins_i(pins), .sck_o(sck_x), .sdi_o(sdi_x), .ss_n_o(ss_n_x));
	// next random state
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want) begin
			num_errors++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : check
	// counts, verdict, stop
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test
	// one classic cycle, held until ack is seen at an edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 40);
		cyc <= 1'b0;
		stb <= 1'b0;
		// a hung bus ends the run
		if (n >= 40) begin
			num_errors++;
			end_of_test();
		end
	endtask : bus
	// read with its expected word queued for the monitor
	task automatic rd(input logic [7:0] a, input logic [31:0] want);
		exp_q.push_back(want);
		bus(1'b0, a, 32'h0);
	endtask : rd
	// monitor: oldest note against each answered read
	always @(posedge clk) begin
		if (cyc && !we && ack === 1'b1 && exp_q.size() > 0) begin
			check(rdat, exp_q.pop_front());
		end
	end
	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rd(SPM_CTRL_OFS, 32'h0);
		check(txq, 1'b0);
		// audio forces idle-high clock; framed mode ignores release
		foreach (pin_tab[i]) begin
			bus(1'b1, SPM_CTRL_OFS, {16'h0, pin_tab[i][17:2]});
			@(negedge clk);
			check({pins.sck, rel}, pin_tab[i][1:0]);
		end
		$display("pin routing test done");
		// tx request per select as the buffer fills; slave idle, no drain
		for (int k = 0; k <= 4; k++) begin
			for (int s = 1; s <= 3; s++) begin
				bus(1'b1, SPM_CTRL_OFS, 32'h8000 | (32'(s) << 2));
				@(negedge clk);
				check(txq, (s == 3) ? (k < 4) : (s == 2) ? (k <= 2) : (k == 0));
			end
			seed = lfsr(seed);
			if (k < 4) last_w = seed[7:0];
			bus(1'b1, SPM_DATA_OFS, {24'h0, seed[7:0]});
		end
		rd(SPM_LVL_OFS, 32'h4);
		// sticky status, masked then enabled, then cleared
		rd(SPM_STAT_OFS, 32'h1);
		check(irq, 1'b0);
		bus(1'b1, SPM_IEN_OFS, 32'h1);
		@(negedge clk);
		check(irq, 1'b1);
		bus(1'b1, SPM_CLR_OFS, 32'h1);
		@(negedge clk);
		check(irq, 1'b0);
		bus(1'b1, SPM_IEN_OFS, 32'h0);
		$display("tx select and interrupt test done");
		// role bit is refused while on, taken while off
		bus(1'b1, SPM_CTRL_OFS, 32'h8020);
		rd(SPM_CTRL_OFS, 32'h8000);
		bus(1'b1, SPM_CTRL_OFS, 32'h0);
		repeat (2) @(posedge clk);
		bus(1'b1, SPM_CTRL_OFS, 32'h20);
		bus(1'b1, SPM_CTRL_OFS, 32'h8020);
		// bounded wait for the done request after the last word
		for (int n = 0; n < 900 && txq !== 1'b1; n++) @(posedge clk);
		check(txq, 1'b1);
		// a done request that never came ends the run
		if (txq !== 1'b1) end_of_test();
		check(pins.sck_oe, 1'b1);
		check(spm_far_inst.in_w, last_w);
		rd(SPM_LVL_OFS, 32'h400);
		// one more word while the receive side is full: sent, dropped, overflow flagged
		seed = lfsr(seed);
		bus(1'b1, SPM_DATA_OFS, {24'h0, seed[7:0]});
		repeat (80) @(posedge clk);
		check(txq, 1'b1);
		check(spm_far_inst.in_w, seed[7:0]);
		rd(SPM_STAT_OFS, 32'h5);
		$display("master transfer test done");
		// rx request per select as software drains the buffer
		for (int k = 4; k >= 0; k--) begin
			for (int s = 1; s <= 3; s++) begin
				bus(1'b1, SPM_CTRL_OFS, 32'h8020 | 32'(s));
				@(negedge clk);
				check(rxq, (s == 3) ? (k == 4) : (s == 2) ? (k >= 2) : (k >= 1));
			end
			if (k > 0) rd(SPM_DATA_OFS, 32'hA5);
		end
		bus(1'b1, SPM_CTRL_OFS, 32'h8020);
		@(negedge clk);
		check(rxq, 1'b1);
		$display("rx select test done");
		// slave role: clock comes from the far side
		bus(1'b1, SPM_CTRL_OFS, 32'h0);
		repeat (2) @(posedge clk);
		bus(1'b1, SPM_CTRL_OFS, 32'h8001);
		@(negedge clk);
		check(pins.sck_oe, 1'b0);
		spm_far_inst.drive_word();
		repeat (8) @(posedge clk);
		check(rxq, 1'b1);
		rd(SPM_DATA_OFS, 32'hA5);
		check(spm_far_inst.in_w, 8'h00);
		rd(8'h40, 32'h0);
		$display("slave transfer test done");
		end_of_test();
	end
endmodule : tb_spi_mode_and_buffer_irq_select
